/* File: src/rxq_pkg.sv */
// Package for the receive buffer block: constants, state numbers and carrier structs.
// Assumes a single 20 MHz core clock domain.
package rxq_pkg;
  localparam int unsigned FIFO_BYTES   = 128;
  localparam int unsigned CNT_W        = 8;
  localparam int unsigned DATA_W       = 8;
  localparam int unsigned STAGE_DEPTH  = 16;
  localparam int unsigned CLK_HZ       = 20000000;
  localparam int unsigned SIGLVL_US    = 128;
  localparam int unsigned SIGLVL_CYC   = (SIGLVL_US * (CLK_HZ / 1000000));
  localparam int unsigned CORR_SYMS    = 8;
  localparam logic [6:0]  CORR_ZERO    = 7'h00;
  localparam logic [7:0]  BYTE_ZERO    = 8'h00;
  localparam logic [7:0]  SIG_MIN      = 8'h80;
  localparam logic [6:0]  THR_RESET    = 7'h40;
  localparam logic        CRC_GOOD     = 1'b1;
  // State numbers of the radio state machine
  localparam logic [5:0] ST_IDLE       = 6'h00;
  localparam logic [5:0] ST_RX_CAL     = 6'h02;
  localparam logic [5:0] ST_SFD_FIRST  = 6'h03;
  localparam logic [5:0] ST_SFD_LAST   = 6'h06;
  localparam logic [5:0] ST_RX_FIRST   = 6'h07;
  localparam logic [5:0] ST_RX_LAST    = 6'h0d;
  localparam logic [5:0] ST_RX2RX      = 6'h0e;
  localparam logic [5:0] ST_BUF_RESET  = 6'h10;
  localparam logic [5:0] ST_RX_OVF     = 6'h11;
  localparam logic [5:0] ST_TX_CAL     = 6'h20;
  localparam logic [5:0] ST_TX_FIRST   = 6'h22;
  localparam logic [5:0] ST_TX_LAST    = 6'h26;
  localparam logic [5:0] ST_TX_FINAL   = 6'h27;
  localparam logic [5:0] ST_TX_TRANSIT = 6'h28;
  localparam logic [5:0] ST_ACK_CAL    = 6'h30;
  localparam logic [5:0] ST_ACK_FIRST  = 6'h31;
  localparam logic [5:0] ST_ACK_LAST   = 6'h36;
  localparam logic [5:0] ST_ACK_DELAY  = 6'h37;
  localparam logic [5:0] ST_TX_UNDER   = 6'h38;
  localparam logic [5:0] ST_TX_SHUT_A  = 6'h1a;
  localparam logic [5:0] ST_TX_SHUT_B  = 6'h39;

  typedef enum logic [3:0] {
    RD_NONE  = 4'b0001,
    RD_HOST  = 4'b0010,
    RD_COPY  = 4'b0100,
    RD_MOVE  = 4'b1000
  } rxq_rd_e;

  // One received byte from the demodulator
  typedef struct packed {
    logic [7:0] data;
    logic       last;   // final payload byte before checksum
    logic       hdr;    // header byte, counted only after acceptance
  } rxq_byte_s;

  // Byte handed out by a read instruction
  typedef struct packed {
    logic [7:0] data;
    logic       to_host;
    logic       to_ram;
  } rxq_out_s;

  typedef struct packed {
    logic [5:0] number;
    logic       tx_busy;
    logic       rx_busy;
  } rxq_state_s;
endpackage : rxq_pkg

/* File: src/rxq_stage_fifo.sv */
// Small valid/ready FIFO staging received bytes ahead of the frame buffer.
// Assumes one clock; flush empties it in one cycle.
`timescale 1ns/1ps
`default_nettype none
module rxq_stage_fifo #(
  parameter int unsigned WIDTH = 10,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             nrst,
  input  wire logic             flush,
  // Fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // Drain side
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_r;
  logic [AW-1:0]    rd_r;
  logic [AW:0]      cnt_r;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_r != DEPTH[AW:0]);
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem[rd_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge core_clk)
  begin
    if (push)
    begin
      mem[wr_r] <= in_data;
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end
    else if (flush)
    begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
      end
      if (pop)
      begin
        rd_r <= (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
      end
      cnt_r <= cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule : rxq_stage_fifo
`default_nettype wire

/* File: src/rxq_top.sv */
// Receive frame buffer with status flags, signal level and state number outputs.
// Assumes the serial host port decodes instructions into one-cycle strobes here.
//
// Summary of operation
// - Buffer holds frames up to 128 bytes
// - Byte count and flags expose fill level
// - Three read instructions: host, copy, move
// - Head peek returns oldest byte, no removal
// - Flush empties buffer, clears flags, errors
// - Nonempty high when bytes, low after overrun
// - Threshold flag when valid count exceeds threshold
// - Filtering excludes header until frame accepted
// - Frame end raises threshold; read drops it
// - Full write: overrun event, flags, halt reception
// - Stored frames stay readable during overrun
// - Rejected frame may still cause overrun
// - Read from empty raises empty-read event
// - Empty-read suppressed on simultaneous byte write
// - Signal level: signed dB, 128 us average
// - Level valid after 8 symbols enabled
// - Energy scan holds peak, else latest
// - Seven bit correlation over eight symbols
// - Receive state numbers and receive-busy flag
// - Transmit state numbers with transmit-busy flag
// - Auto checksum replaces checksum with status
// - Checksum-good bit one when correct
`timescale 1ns/1ps
`default_nettype none
module rxq_top
  import rxq_pkg::*;
#(
  parameter int unsigned DEPTH       = FIFO_BYTES,
  parameter int unsigned STAGE       = STAGE_DEPTH,
  parameter int unsigned LEVEL_CYCLES = SIGLVL_CYC
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       nrst,
  // Received byte stream
  input  wire rxq_byte_s  rx_byte,
  input  wire logic       rx_byte_valid,
  output logic            rx_byte_ready,
  input  wire logic       frame_accepted,
  input  wire logic       frame_rejected,
  input  wire logic       checksum_ok,
  // Host instructions
  input  wire rxq_rd_e    read_cmd,
  input  wire logic       receive_flush_strobe,
  input  wire logic [6:0] threshold_value,
  input  wire logic       frame_filter_enable,
  input  wire logic       auto_checksum,
  // Buffer outputs
  output rxq_out_s        read_out,
  output logic            read_out_valid,
  output logic [7:0]      head_peek,
  output logic [7:0]      rx_byte_count,
  output logic            io_pin_one,
  output logic            io_pin_two,
  output logic            rx_overflow_event,
  output logic            rx_underflow_event,
  // Signal quality
  input  wire logic       rx_enable,
  input  wire logic [7:0] power_sample,
  input  wire logic       power_sample_valid,
  input  wire logic       energy_scan,
  input  wire logic [6:0] corr_sample,
  input  wire logic       corr_sample_valid,
  output logic [7:0]      signal_level,
  output logic            signal_level_valid,
  output logic [6:0]      correlation,
  // Radio state
  input  wire logic [5:0] radio_state,
  output rxq_state_s      state_number_register
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned SW = $bits(rxq_byte_s);
  localparam int unsigned LW = $clog2(LEVEL_CYCLES + 1);

  logic [7:0]    mem [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0]   cnt_r;
  logic [AW:0]   hold_r;      // header bytes not yet accepted
  logic          ovf_r;
  logic          eof_r;       // frame-end flag holding threshold flag until the next read
  logic          hdr_run_r;
  logic          tail_r;      // appending status byte pending
  rxq_byte_s     stg_data;
  logic          stg_valid;
  logic          stg_ready;
  logic          wr_en;
  logic [7:0]    wr_byte;
  logic          rd_en;
  logic          full;
  logic [AW:0]   valid_cnt;
  logic [AW:0]   cnt_nxt;
  logic [AW:0]   hold_nxt;
  logic [LW-1:0] lvl_cnt_r;
  logic [10:0]   pwr_acc_r;
  logic [2:0]    pwr_n_r;
  logic [9:0]    corr_acc_r;
  logic [3:0]    corr_n_r;
  logic [7:0]    avg_pwr;

  rxq_stage_fifo #(.WIDTH(SW), .DEPTH(STAGE)) u_stage (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .flush     (receive_flush_strobe),
    .in_valid  (rx_byte_valid && !ovf_r),
    .in_data   (rx_byte),
    .in_ready  (rx_byte_ready),
    .out_valid (stg_valid),
    .out_data  (stg_data),
    .out_ready (stg_ready)
  );

  // Drain stalls for the status tail; overrun stops reception
  assign stg_ready = !ovf_r && !tail_r && !receive_flush_strobe;
  assign full      = (cnt_r == DEPTH[AW:0]);
  // Auto checksum: last payload byte is followed by status, not checksum
  assign wr_en     = !ovf_r && !receive_flush_strobe && !full && (tail_r || stg_valid);
  assign wr_byte   = tail_r ? {checksum_ok, correlation} : stg_data.data;
  // Overrun keeps stored bytes readable
  assign rd_en     = (read_cmd != RD_NONE) && (cnt_r != '0) && !receive_flush_strobe;
  assign valid_cnt = cnt_r - hold_r;

  // Buffer write and read pointers
  always_ff @(posedge core_clk)
  begin
    if (wr_en)
    begin
      mem[wr_r] <= wr_byte;
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_r <= '0;
      rd_r <= '0;
    end
    else if (receive_flush_strobe)
    begin
      wr_r <= '0;
      rd_r <= '0;
    end
    else
    begin
      if (wr_en)
      begin
        wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
      end
      if (rd_en)
      begin
        rd_r <= (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
      end
    end
  end

  always_comb
  begin
    cnt_nxt  = cnt_r + {{AW{1'b0}}, wr_en} - {{AW{1'b0}}, rd_en};
    hold_nxt = hold_r;
    if (frame_accepted || !frame_filter_enable)
    begin
      hold_nxt = '0;
    end
    else if (wr_en && !tail_r && stg_data.hdr)
    begin
      hold_nxt = hold_r + 1'b1;
    end
    // Reads consume accepted bytes first; never let hold exceed count
    if (hold_nxt > cnt_nxt)
    begin
      hold_nxt = cnt_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_r     <= '0;
      hold_r    <= '0;
      tail_r    <= 1'b0;
      hdr_run_r <= 1'b0;
    end
    else if (receive_flush_strobe)
    begin
      cnt_r     <= '0;
      hold_r    <= '0;
      tail_r    <= 1'b0;
      hdr_run_r <= 1'b0;
    end
    else
    begin
      cnt_r     <= cnt_nxt;
      hold_r    <= hold_nxt;
      hdr_run_r <= frame_rejected ? 1'b0 : hdr_run_r;
      if (wr_en && tail_r)
      begin
        tail_r <= 1'b0;
      end
      else if (wr_en && stg_data.last && auto_checksum)
      begin
        tail_r <= 1'b1;
      end
    end
  end

  // Overrun: byte arrives with buffer full, even for a later-rejected frame
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ovf_r             <= 1'b0;
      rx_overflow_event <= 1'b0;
    end
    else if (receive_flush_strobe)
    begin
      ovf_r             <= 1'b0;
      rx_overflow_event <= 1'b0;
    end
    else
    begin
      rx_overflow_event <= !ovf_r && full && !rd_en && (stg_valid || tail_r);
      if (!ovf_r && full && !rd_en && (stg_valid || tail_r))
      begin
        ovf_r <= 1'b1;
      end
    end
  end

  // Empty read event, not when a byte lands in the same cycle
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rx_underflow_event <= 1'b0;
    end
    else
    begin
      rx_underflow_event <= (read_cmd != RD_NONE) && (cnt_r == '0) && !wr_en && !receive_flush_strobe;
    end
  end

  // Frame-end flag: set wins over read clear
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      eof_r <= 1'b0;
    end
    else if (receive_flush_strobe)
    begin
      eof_r <= 1'b0;
    end
    else if (wr_en && (auto_checksum ? tail_r : stg_data.last))
    begin
      eof_r <= 1'b1;
    end
    else if (rd_en)
    begin
      eof_r <= 1'b0;
    end
  end

  // Status outputs track next-cycle count so they move with the access
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      io_pin_one     <= 1'b0;
      io_pin_two     <= 1'b0;
      rx_byte_count  <= BYTE_ZERO;
      head_peek      <= BYTE_ZERO;
      read_out       <= '0;
      read_out_valid <= 1'b0;
    end
    else
    begin
      rx_byte_count  <= receive_flush_strobe ? BYTE_ZERO : 8'(cnt_nxt);
      io_pin_one     <= (cnt_nxt != '0) && !(ovf_r || rx_overflow_event) && !receive_flush_strobe;
      io_pin_two     <= !receive_flush_strobe &&
                        ((ovf_r || rx_overflow_event) ||
                         ((cnt_nxt - hold_nxt) > (AW + 1)'(threshold_value)) ||
                         (wr_en && (auto_checksum ? tail_r : stg_data.last)) ||
                         (eof_r && !rd_en));
      // Peek shows the oldest byte; no pointer moves
      head_peek      <= (cnt_r == '0) ? BYTE_ZERO : mem[rd_r];
      read_out_valid <= rd_en;
      read_out.data  <= mem[rd_r];
      read_out.to_host <= (read_cmd == RD_HOST) || (read_cmd == RD_COPY);
      read_out.to_ram  <= (read_cmd == RD_COPY) || (read_cmd == RD_MOVE);
    end
  end

  // Signal level over 8 samples, valid after enable window
  // Full new window average; the partial sum would let the peak sag
  assign avg_pwr = 8'(($signed(pwr_acc_r + {{3{power_sample[7]}}, power_sample})) >>> 3);
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      lvl_cnt_r          <= '0;
      pwr_acc_r          <= '0;
      pwr_n_r            <= '0;
      signal_level       <= SIG_MIN;
      signal_level_valid <= 1'b0;
    end
    else if (!rx_enable)
    begin
      lvl_cnt_r          <= '0;
      pwr_acc_r          <= '0;
      pwr_n_r            <= '0;
      signal_level_valid <= 1'b0;
    end
    else
    begin
      if (lvl_cnt_r != LW'(LEVEL_CYCLES))
      begin
        lvl_cnt_r <= lvl_cnt_r + 1'b1;
      end
      signal_level_valid <= (lvl_cnt_r == LW'(LEVEL_CYCLES));
      if (power_sample_valid)
      begin
        pwr_n_r   <= pwr_n_r + 1'b1;
        pwr_acc_r <= (pwr_n_r == 3'h7) ? '0 : pwr_acc_r + {{3{power_sample[7]}}, power_sample};
        if (pwr_n_r == 3'h7)
        begin
          // Peak hold in energy scan, else latest average
          if (!energy_scan || !signal_level_valid || ($signed(avg_pwr) > $signed(signal_level)))
          begin
            signal_level <= avg_pwr;
          end
        end
      end
    end
  end

  // Correlation averaged over eight symbols per frame
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      corr_acc_r  <= '0;
      corr_n_r    <= '0;
      correlation <= CORR_ZERO;
    end
    else if (!rx_enable)
    begin
      corr_acc_r <= '0;
      corr_n_r   <= '0;
    end
    else if (wr_en && !tail_r && stg_data.last)
    begin
      // Frame end rearms the window for the next frame
      corr_acc_r <= '0;
      corr_n_r   <= '0;
    end
    else if (corr_sample_valid && (corr_n_r != 4'(CORR_SYMS)))
    begin
      corr_acc_r <= corr_acc_r + {3'h0, corr_sample};
      corr_n_r   <= corr_n_r + 1'b1;
      if (corr_n_r == 4'(CORR_SYMS - 1))
      begin
        correlation <= 7'((corr_acc_r + {3'h0, corr_sample}) >> 3);
      end
    end
  end

  // State number with busy flags
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_number_register <= '0;
    end
    else
    begin
      state_number_register.number  <= radio_state;
      state_number_register.rx_busy <= (radio_state >= ST_RX_CAL) && (radio_state <= ST_BUF_RESET);
      state_number_register.tx_busy <= (radio_state >= ST_TX_CAL) || (radio_state == ST_TX_SHUT_A);
    end
  end

  property p_ovf_flags;
    @(posedge core_clk) disable iff (!nrst)
      rx_overflow_event && !receive_flush_strobe |=> !io_pin_one && io_pin_two;
  endproperty
  a_ovf_flags: assert property (p_ovf_flags) else $error("overrun flags wrong");

  property p_count_max;
    @(posedge core_clk) disable iff (!nrst) rx_byte_count <= 8'(DEPTH);
  endproperty
  a_count_max: assert property (p_count_max) else $error("count above capacity");

  property p_flush;
    @(posedge core_clk) disable iff (!nrst)
      receive_flush_strobe |=> rx_byte_count == BYTE_ZERO && !io_pin_one && !io_pin_two;
  endproperty
  a_flush: assert property (p_flush) else $error("flush did not clear");

  property p_read_dec;
    @(posedge core_clk) disable iff (!nrst)
      rd_en && !wr_en |=> rx_byte_count == $past(rx_byte_count) - 8'h01;
  endproperty
  a_read_dec: assert property (p_read_dec) else $error("read did not decrement");

  property p_under;
    @(posedge core_clk) disable iff (!nrst)
      rx_underflow_event |-> $past(cnt_r) == '0 && !$past(wr_en);
  endproperty
  a_under: assert property (p_under) else $error("bad empty-read event");

  property p_nonempty;
    @(posedge core_clk) disable iff (!nrst)
      io_pin_one |-> rx_byte_count != BYTE_ZERO;
  endproperty
  a_nonempty: assert property (p_nonempty) else $error("nonempty with no bytes");

  sequence s_ovf_set;
    !ovf_r ##1 ovf_r;
  endsequence
  property p_halt;
    @(posedge core_clk) disable iff (!nrst)
      s_ovf_set ##0 !receive_flush_strobe |=> rx_byte_count <= $past(rx_byte_count);
  endproperty
  a_halt: assert property (p_halt) else $error("write during overrun");

  property p_rxbusy;
    @(posedge core_clk) disable iff (!nrst)
      $past(radio_state) == ST_RX_OVF |-> !state_number_register.rx_busy;
  endproperty
  a_rxbusy: assert property (p_rxbusy) else $error("busy in overrun");

  property p_valid_late;
    @(posedge core_clk) disable iff (!nrst)
      $rose(rx_enable) |-> !signal_level_valid [*8];
  endproperty
  a_valid_late: assert property (p_valid_late) else $error("level valid too early");
endmodule : rxq_top
`default_nettype wire

/* File: verif/rxq_host_model.sv */
// Host side model: turns bench requests into read strobes and threshold writes.
// Assumes requests arrive as one-cycle pulses on the core clock.
`timescale 1ns/1ps
`default_nettype none
module rxq_host_model
  import rxq_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       nrst,
  // Bench requests
  input  wire logic       rd_req,
  input  wire rxq_rd_e    rd_kind,
  input  wire logic       thr_load,
  input  wire logic [6:0] thr_in,
  // Toward the block
  output rxq_rd_e         read_cmd,
  output logic [6:0]      threshold_value
);
  // One byte per strobe, so a held request would read many bytes
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst) read_cmd <= RD_NONE;
    else read_cmd <= rd_req ? rd_kind : RD_NONE;
  end
  // Loaded only on a thr_load pulse and held between loads; reset loads THR_RESET
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst) threshold_value <= THR_RESET;
    else if (thr_load) threshold_value <= thr_in;
  end
endmodule : rxq_host_model
`default_nettype wire

/* File: verif/testbench.sv */
// Self-checking bench for the receive buffer block.
// Assumes the host model above and a reduced signal level window.
`timescale 1ns/1ps
`default_nettype none
module testbench
  import rxq_pkg::*;
;
  logic core_clk, nrst, rx_byte_valid, rx_byte_ready, flush;
  logic rd_req, thr_load, read_out_valid, pin1, pin2, ovf, udf;
  logic rx_enable, psv, energy_scan, csv, lvl_ok, acc, ac, ffe, cok, hdr_b;
  logic [6:0] thr_in, thr, corr_sample, corr;
  logic [7:0] head, count, power_sample, level;
  logic [5:0] radio_state;
  rxq_byte_s rx_byte;
  rxq_rd_e rd_kind, read_cmd;
  rxq_out_s read_out;
  rxq_state_s st;
  logic [7:0] q[$];
  int seed = 98224;
  int fail_count = 0;
  int check_count = 0;
  int ovf_n = 0;
  int udf_n = 0;
  rxq_rd_e kinds[3] = '{RD_HOST, RD_COPY, RD_MOVE};

  rxq_host_model i_host (.core_clk(core_clk), .nrst(nrst), .rd_req(rd_req), .rd_kind(rd_kind),
    .thr_load(thr_load), .thr_in(thr_in), .read_cmd(read_cmd), .threshold_value(thr));
  rxq_top #(.LEVEL_CYCLES(16)) i_dut (.core_clk(core_clk), .nrst(nrst), .rx_byte(rx_byte),
    .rx_byte_valid(rx_byte_valid), .rx_byte_ready(rx_byte_ready), .frame_accepted(acc),
    .frame_rejected(1'b0), .checksum_ok(cok), .read_cmd(read_cmd), .receive_flush_strobe(flush),
    .threshold_value(thr), .frame_filter_enable(ffe), .auto_checksum(ac), .read_out(read_out),
    .read_out_valid(read_out_valid), .head_peek(head), .rx_byte_count(count), .io_pin_one(pin1),
    .io_pin_two(pin2), .rx_overflow_event(ovf), .rx_underflow_event(udf), .rx_enable(rx_enable),
    .power_sample(power_sample), .power_sample_valid(psv), .energy_scan(energy_scan),
    .corr_sample(corr_sample), .corr_sample_valid(csv), .signal_level(level),
    .signal_level_valid(lvl_ok), .correlation(corr), .radio_state(radio_state),
    .state_number_register(st));

  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // Event pulses last one cycle, so they are counted as they pass
  always @(posedge core_clk)
  begin
    if (ovf === 1'b1) ovf_n++;
    if (udf === 1'b1) udf_n++;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask : chk

  function automatic logic [7:0] st_exp(input logic [5:0] s);
    return {s, (s >= 6'h20) || (s == 6'h1a), (s >= 6'h02) && (s <= 6'h10)};
  endfunction : st_exp

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc

  task automatic set_thr(input logic [6:0] t);
    thr_load <= 1'b1;
    thr_in   <= t;
    cyc(1);
    thr_load <= 1'b0;
    cyc(1);
  endtask : set_thr

  // Back to back bytes; valid stays up between them
  task automatic send(input int n, input logic fin);
    logic [7:0] d;
    int g;
    for (int i = 0; i < n; i++)
    begin
      d = $random(seed);
      rx_byte       <= '{data: d, last: fin && (i == n - 1), hdr: hdr_b};
      rx_byte_valid <= 1'b1;
      g = 0;
      @(negedge core_clk);
      while (rx_byte_ready !== 1'b1 && g < 100)
      begin
        g++;
        @(negedge core_clk);
      end
      @(posedge core_clk);
      if (q.size() < FIFO_BYTES) q.push_back(d);
    end
    rx_byte_valid <= 1'b0;
    cyc(3);
  endtask : send

  task automatic rd(input rxq_rd_e k);
    logic [7:0] e;
    int g;
    e = q.pop_front();
    rd_req  <= 1'b1;
    rd_kind <= k;
    cyc(1);
    rd_req <= 1'b0;
    g = 0;
    do
    begin
      @(posedge core_clk);
      #1;
      g++;
    end
    while (read_out_valid !== 1'b1 && g < 5);
    chk(read_out.data, e);
    chk({6'h0, read_out.to_host, read_out.to_ram}, {6'h0, k != RD_MOVE, k != RD_HOST});
  endtask : rd

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test

  initial
  begin
    #1000000;
    fail_count++;
    end_of_test();
  end

  initial
  begin
    int n;
    int u;
    nrst = 1'b0; rx_byte = '0; rx_byte_valid = 1'b0; flush = 1'b0; rd_req = 1'b0;
    rd_kind = RD_NONE; thr_load = 1'b0; thr_in = 7'h00; acc = 1'b0; rx_enable = 1'b0;
    power_sample = 8'h00; psv = 1'b0; energy_scan = 1'b0; corr_sample = 7'h00;
    csv = 1'b0; radio_state = 6'h00;
    ac = 1'b0; ffe = 1'b0; cok = 1'b1; hdr_b = 1'b0;
    cyc(2);
    nrst <= 1'b1;
    cyc(1);
    #1;
    chk(count, 8'h00);
    chk(level, SIG_MIN);
    chk({5'h0, pin1, pin2, rx_byte_ready}, 8'h01);
    // Threshold crossing and head peek
    set_thr(7'h03);
    send(5, 1'b0);
    #1;
    chk(count, 8'h05);
    chk({6'h0, pin1, pin2}, 8'h03);
    chk(head, q[0]);
    chk(count, 8'h05);
    rd(RD_HOST);
    rd(RD_COPY);
    cyc(1);
    #1;
    chk(count, 8'h03);
    chk({7'h0, pin2}, 8'h00);
    // Frame end lifts the threshold flag until the next read
    set_thr(7'h64);
    send(2, 1'b1);
    #1;
    chk({7'h0, pin2}, 8'h01);
    rd(RD_MOVE);
    cyc(1);
    #1;
    chk({7'h0, pin2}, 8'h00);
    while (q.size() > 0) rd(RD_HOST);
    cyc(2);
    #1;
    chk({6'h0, pin1, pin2}, 8'h00);
    // Read from an empty buffer
    u = udf_n;
    rd_req  <= 1'b1;
    rd_kind <= RD_HOST;
    cyc(1);
    rd_req <= 1'b0;
    cyc(4);
    chk(udf_n - u, 8'h01);
    // Random bursts drained by random instructions
    for (int r = 0; r < 6; r++)
    begin
      n = 1 + ($unsigned($random(seed)) % 24);
      send(n, r[0]);
      #1;
      chk(count, n[7:0]);
      while (q.size() > 0) rd(kinds[$unsigned($random(seed)) % 3]);
    end
    // Overrun: one byte past full
    send(FIFO_BYTES + 1, 1'b0);
    cyc(4);
    #1;
    chk({6'h0, pin1, pin2}, 8'h01);
    chk({7'h0, ovf_n > 0}, 8'h01);
    rd(RD_HOST);
    flush <= 1'b1;
    cyc(1);
    flush <= 1'b0;
    cyc(1);
    #1;
    q.delete();
    chk(count, 8'h00);
    chk({6'h0, pin1, pin2}, 8'h00);
    // Signal level: latest value, then peak hold
    power_sample <= $random(seed);
    psv          <= 1'b1;
    rx_enable    <= 1'b1;
    cyc(3);
    #1;
    chk({7'h0, lvl_ok}, 8'h00);
    cyc(40);
    #1;
    chk({7'h0, lvl_ok}, 8'h01);
    chk(level, power_sample);
    n = power_sample;
    energy_scan  <= 1'b1;
    power_sample <= SIG_MIN;
    cyc(40);
    #1;
    chk(level, n[7:0]);
    energy_scan <= 1'b0;
    cyc(40);
    #1;
    chk(level, SIG_MIN);
    // Correlation over eight random samples
    n = 0;
    for (int i = 0; i < CORR_SYMS; i++)
    begin
      u = $random(seed);
      corr_sample <= u[6:0];
      csv         <= 1'b1;
      n           += u[6:0];
      cyc(1);
    end
    csv <= 1'b0;
    cyc(2);
    #1;
    chk({1'b0, corr}, 8'(n / 8));
    // Auto checksum: one status byte follows the frame's last byte
    ac  <= 1'b1;
    cok <= n[0];
    send(3, 1'b1);
    q.push_back({n[0], 7'(n / 8)});
    #1;
    chk(count, 8'h04);
    while (q.size() > 0) rd(RD_HOST);
    // Filtering: header bytes count only once the frame is accepted
    ac    <= 1'b0;
    ffe   <= 1'b1;
    hdr_b = 1'b1;
    set_thr(7'h02);
    send(4, 1'b0);
    #1;
    chk({6'h0, pin1, pin2}, 8'h02);
    acc <= 1'b1;
    cyc(1);
    acc <= 1'b0;
    cyc(1);
    #1;
    chk({7'h0, pin2}, 8'h01);
    hdr_b = 1'b0;
    ffe   <= 1'b0;
    while (q.size() > 0) rd(RD_HOST);
    // Every state number and its busy flags; never steers the run
    for (int s = 0; s < 64; s++)
    begin
      radio_state <= s[5:0];
      cyc(2);
      #1;
      chk(st, st_exp(s[5:0]));
    end
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
